/* File: logic/fpsc_ctrl.v */
`timescale 1ns/10ps
`default_nettype none
`include "fpsc_consts.vh"
module fpsc_ctrl #(
  parameter [15:0] SLEEP_ENTRY_CYC = `FPSC_SLEEP_ENTRY_CYC,
  parameter [15:0] WAKE_RECOVERY_CYC = `FPSC_WAKE_RECOVERY_CYC,
  parameter [15:0] SUSPEND_MAX_CYC = `FPSC_SUSPEND_MAX_CYC,
  parameter [127:0] UNIQUE_ID = 128'h0123456789abcdeffedcba9876543210, // arbitrary value
  parameter [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter [7:0] MEM_TYPE_ID = 8'h3c, // arbitrary value
  parameter [7:0] CAPACITY_ID = 8'h1b, // arbitrary value
  parameter [7:0] EXTRA_ID = 8'h00 // arbitrary value
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_cs_n,
  input wire i_sclk,
  input wire [3:0] i_io,
  input wire i_quad_mode,
  input wire i_addr4_mode,
  input wire i_sclk_fast,
  input wire i_cycle_start,
  input wire i_cycle_is_prog,
  input wire i_cycle_is_erase,
  input wire i_cycle_done,
  output wire [3:0] o_io,
  output wire [3:0] o_io_oe,
  output wire o_busy_cycle_flag,
  output wire [1:0] o_suspend_flags,
  output wire o_array_halt,
  output wire o_deep_sleep,
  output wire o_standby,
  output wire o_cmd_valid,
  output wire [7:0] o_cmd_code,
  output wire o_soft_reset
);
  localparam [1:0] ST_AWAKE = 2'h0;
  localparam [1:0] ST_ENTER = 2'h1;
  localparam [1:0] ST_SLEEP = 2'h2;
  localparam [1:0] ST_WAKE = 2'h3;
  localparam [1:0] MD_NONE = 2'h0;
  localparam [1:0] MD_UID = 2'h1;
  localparam [1:0] MD_ID = 2'h2;

  // ****************************************
  // pin synchronisation and edge detection
  // ****************************************
  wire [5:0] pins_s;
  reg [1:0] edge_r;
  wire cs_n_s;
  wire sclk_s;
  wire [3:0] io_s;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_rise;

  fpsc_sync #(
    .WIDTH(6),
    .RESET_VAL(6'h20)
  ) u_sync (
    .i_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_cs_n, i_sclk, i_io}),
    .o_sync(pins_s)
  );

  assign cs_n_s = pins_s[5];
  assign sclk_s = pins_s[4];
  assign io_s = pins_s[3:0];

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      edge_r <= 2'h2;
    end else begin
      edge_r <= {cs_n_s, sclk_s};
    end
  end

  assign sclk_rise = !cs_n_s && sclk_s && !edge_r[0];
  assign sclk_fall = !cs_n_s && !sclk_s && edge_r[0];
  assign cs_rise = cs_n_s && !edge_r[1];

  // ****************************************
  // command byte capture
  // ****************************************
  reg [7:0] cmd_r;
  reg [7:0] clk_cnt_r;
  wire [7:0] byte_clks;
  wire [7:0] cmd_nxt;
  wire cmd_done;
  wire cmd_exact;

  assign byte_clks = i_quad_mode ? `FPSC_BYTE_CLKS_QUAD : `FPSC_BYTE_CLKS_SPI;
  assign cmd_nxt = i_quad_mode ? {cmd_r[3:0], io_s} : {cmd_r[6:0], io_s[0]};
  assign cmd_done = sclk_rise && (clk_cnt_r == byte_clks - 8'h01);
  // select must rise with exactly one byte of clocks behind it
  assign cmd_exact = cs_rise && (clk_cnt_r == byte_clks);

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_r <= 8'h00;
      clk_cnt_r <= 8'h00;
    end else if (cs_n_s) begin
      clk_cnt_r <= 8'h00;
    end else if (sclk_rise) begin
      if (clk_cnt_r < byte_clks) begin
        cmd_r <= cmd_nxt;
      end
      if (clk_cnt_r != `FPSC_CNT_MAX) begin
        clk_cnt_r <= clk_cnt_r + 8'h01;
      end
    end
  end

  // ****************************************
  // power state and busy / suspend tracking
  // ****************************************
  reg [1:0] pwr_st_r;
  reg [15:0] pwr_tmr_r;
  reg busy_r;
  reg kind_prog_r;
  reg kind_erase_r;
  reg [1:0] susp_r;
  reg halt_r;
  reg [15:0] sus_tmr_r;
  reg rst_en_r;
  reg soft_rst_r;
  wire awake;
  wire do_sleep;
  wire do_wake;
  wire do_reset;
  wire do_pause;
  wire do_continue;

  assign awake = (pwr_st_r == ST_AWAKE);
  assign do_sleep = cmd_exact && awake && (cmd_r == `FPSC_OP_DEEP_SLEEP) && !busy_r;
  assign do_wake = cmd_exact && (pwr_st_r == ST_SLEEP) && (cmd_r == `FPSC_OP_WAKE) && !busy_r;
  assign do_reset = cmd_exact && (awake || pwr_st_r == ST_SLEEP) && (cmd_r == `FPSC_OP_RST) && rst_en_r;
  assign do_pause = cmd_exact && awake && (cmd_r == `FPSC_OP_PAUSE) && (susp_r == 2'h0) && busy_r &&
    (kind_prog_r || kind_erase_r) && (sus_tmr_r == 16'h0000);
  assign do_continue = cmd_exact && awake && (cmd_r == `FPSC_OP_CONTINUE) && (susp_r != 2'h0) && !busy_r;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_st_r <= ST_AWAKE;
      pwr_tmr_r <= 16'h0000;
    end else begin
      case (pwr_st_r)
        ST_AWAKE: begin
          if (do_sleep) begin
            pwr_st_r <= ST_ENTER;
            pwr_tmr_r <= SLEEP_ENTRY_CYC;
          end
        end
        ST_ENTER: begin
          // commands arriving during the entry delay are dropped
          if (pwr_tmr_r <= 16'h0001) begin
            pwr_st_r <= ST_SLEEP;
          end else begin
            pwr_tmr_r <= pwr_tmr_r - 16'h0001;
          end
        end
        ST_SLEEP: begin
          if (do_reset) begin
            pwr_st_r <= ST_AWAKE;
          end else if (do_wake) begin
            pwr_st_r <= ST_WAKE;
            pwr_tmr_r <= WAKE_RECOVERY_CYC;
          end
        end
        ST_WAKE: begin
          if (pwr_tmr_r <= 16'h0001) begin
            pwr_st_r <= ST_AWAKE;
          end else begin
            pwr_tmr_r <= pwr_tmr_r - 16'h0001;
          end
        end
        default: begin
          pwr_st_r <= ST_AWAKE;
        end
      endcase
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_en_r <= 1'b0;
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= do_reset;
      if (cmd_exact && (awake || pwr_st_r == ST_SLEEP)) begin
        // any other complete command taken while awake or asleep disarms the pair
        rst_en_r <= (cmd_r == `FPSC_OP_RST_EN);
      end
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_r <= 1'b0;
      kind_prog_r <= 1'b0;
      kind_erase_r <= 1'b0;
      susp_r <= 2'h0;
      halt_r <= 1'b0;
      sus_tmr_r <= 16'h0000;
    end else begin
      // a fresh cycle start wins over any clear in the same cycle
      if (i_cycle_start) begin
        busy_r <= 1'b1;
        kind_prog_r <= i_cycle_is_prog;
        kind_erase_r <= i_cycle_is_erase && !i_cycle_is_prog;
      end else if (i_cycle_done) begin
        busy_r <= 1'b0;
      end else if (sus_tmr_r == 16'h0001) begin
        busy_r <= 1'b0;
      end else if (do_continue) begin
        busy_r <= 1'b1;
      end
      if (do_pause) begin
        sus_tmr_r <= SUSPEND_MAX_CYC;
      end else if (sus_tmr_r != 16'h0000) begin
        sus_tmr_r <= sus_tmr_r - 16'h0001;
      end
      if (do_reset) begin
        susp_r <= 2'h0;
        halt_r <= 1'b0;
        sus_tmr_r <= 16'h0000;
      end else if (do_pause) begin
        susp_r[`FPSC_SUSP_PROG_BIT] <= kind_prog_r;
        susp_r[`FPSC_SUSP_ERASE_BIT] <= kind_erase_r;
        halt_r <= 1'b1;
      end else if (do_continue) begin
        susp_r <= 2'h0;
        halt_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // refusal of erase and register-write commands while suspended, and of program commands during program suspend
  // ****************************************
  reg is_reg_wr;
  reg is_erase;
  reg is_prog;
  wire refused;

  always @* begin
    is_reg_wr = (cmd_nxt == `FPSC_OP_WRSR) || (cmd_nxt == `FPSC_OP_WRNVCR);
    is_erase = 1'b0;
    is_prog = 1'b0;
    case (cmd_nxt)
      `FPSC_OP_SE_A, `FPSC_OP_SE_B, `FPSC_OP_BE32_A, `FPSC_OP_BE32_B, `FPSC_OP_BE64_A, `FPSC_OP_BE64_B,
      `FPSC_OP_CE_A, `FPSC_OP_CE_B: begin
        is_erase = 1'b1;
      end
      `FPSC_OP_PP_A, `FPSC_OP_PP_B, `FPSC_OP_QPP_A, `FPSC_OP_QPP_B, `FPSC_OP_EPP_A, `FPSC_OP_EPP_B: begin
        is_prog = 1'b1;
      end
      default: begin
        is_erase = 1'b0;
      end
    endcase
  end

  assign refused = (susp_r[`FPSC_SUSP_PROG_BIT] && (is_reg_wr || is_erase || is_prog ||
    cmd_nxt == `FPSC_OP_SEC_ERASE || cmd_nxt == `FPSC_OP_SEC_PROG)) ||
    (susp_r[`FPSC_SUSP_ERASE_BIT] && (is_reg_wr || is_erase || cmd_nxt == `FPSC_OP_SEC_ERASE));

  // ****************************************
  // decode, forwarding and readout
  // ****************************************
  reg [1:0] mode_r;
  reg [7:0] out_at_r;
  reg [127:0] out_sr_r;
  reg [3:0] io_r;
  reg [3:0] oe_r;
  reg fwd_r;
  reg [7:0] fwd_code_r;
  reg local_op;
  wire is_id;
  wire [7:0] uid_at;
  wire [7:0] id_at;
  wire [31:0] id_word;

  assign is_id = (cmd_nxt == `FPSC_OP_ID_A) || (cmd_nxt == `FPSC_OP_ID_B);
  // command, address bytes and one dummy byte precede the number
  assign uid_at = byte_clks * (i_addr4_mode ? `FPSC_UID_FRAME_BYTES_4B : `FPSC_UID_FRAME_BYTES_3B);
  assign id_at = byte_clks + ((i_quad_mode && i_sclk_fast) ? `FPSC_ID_QUAD_DUMMY : 8'h00);
  assign id_word = {MAKER_ID, MEM_TYPE_ID, CAPACITY_ID, EXTRA_ID};

  always @* begin
    case (cmd_nxt)
      `FPSC_OP_DEEP_SLEEP, `FPSC_OP_WAKE, `FPSC_OP_RST_EN, `FPSC_OP_RST, `FPSC_OP_UID, `FPSC_OP_ID_A,
      `FPSC_OP_ID_B, `FPSC_OP_PAUSE, `FPSC_OP_CONTINUE: begin
        local_op = 1'b1;
      end
      default: begin
        local_op = 1'b0;
      end
    endcase
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= MD_NONE;
      out_at_r <= 8'h00;
      out_sr_r <= 128'h0;
      io_r <= 4'h0;
      oe_r <= 4'h0;
      fwd_r <= 1'b0;
      fwd_code_r <= 8'h00;
    end else begin
      fwd_r <= 1'b0;
      if (cs_n_s) begin
        mode_r <= MD_NONE;
        oe_r <= 4'h0;
      end else if (cmd_done && awake) begin
        if (cmd_nxt == `FPSC_OP_UID) begin
          mode_r <= MD_UID;
          out_at_r <= uid_at;
          out_sr_r <= UNIQUE_ID;
        end else if (is_id && !busy_r) begin
          mode_r <= MD_ID;
          out_at_r <= id_at;
          // repeated so the rotation wraps on the 32-bit word
          out_sr_r <= {id_word, id_word, id_word, id_word};
        end else if (!local_op && !refused) begin
          fwd_r <= 1'b1;
          fwd_code_r <= cmd_nxt;
        end
      end else if (sclk_fall && mode_r != MD_NONE && clk_cnt_r >= out_at_r) begin
        if (i_quad_mode) begin
          io_r <= out_sr_r[127:124];
          out_sr_r <= {out_sr_r[123:0], out_sr_r[127:124]};
          oe_r <= 4'hf;
        end else begin
          io_r <= {2'h0, out_sr_r[127], 1'b0};
          out_sr_r <= {out_sr_r[126:0], out_sr_r[127]};
          oe_r <= 4'h2;
        end
      end
    end
  end

  assign o_io = io_r;
  assign o_io_oe = oe_r;
  assign o_busy_cycle_flag = busy_r;
  assign o_suspend_flags = susp_r;
  assign o_array_halt = halt_r;
  assign o_deep_sleep = (pwr_st_r == ST_SLEEP);
  assign o_standby = cs_n_s && !busy_r && awake;
  assign o_cmd_valid = fwd_r;
  assign o_cmd_code = fwd_code_r;
  assign o_soft_reset = soft_rst_r;
endmodule // fpsc_ctrl
`default_nettype wire

/* File: logic/fpsc_sync.v */
`timescale 1ns/10ps
`default_nettype none
module fpsc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule // fpsc_sync
`default_nettype wire

/* File: logic/README_none.v */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: pkg/fpsc_consts.vh */
`ifndef FPSC_CONSTS_VH
`define FPSC_CONSTS_VH

// ****************************************
// command codes
// ****************************************
`define FPSC_OP_DEEP_SLEEP 8'hb9
`define FPSC_OP_WAKE 8'hab
`define FPSC_OP_RST_EN 8'h66
`define FPSC_OP_RST 8'h99
`define FPSC_OP_UID 8'h4b
`define FPSC_OP_ID_A 8'h9f
`define FPSC_OP_ID_B 8'h9e
`define FPSC_OP_PAUSE 8'h75
`define FPSC_OP_CONTINUE 8'h7a
`define FPSC_OP_WRSR 8'h01
`define FPSC_OP_WRNVCR 8'hb1
`define FPSC_OP_SEC_ERASE 8'h44
`define FPSC_OP_SEC_PROG 8'h42
`define FPSC_OP_SE_A 8'h20
`define FPSC_OP_SE_B 8'h21
`define FPSC_OP_BE32_A 8'h52
`define FPSC_OP_BE32_B 8'h5c
`define FPSC_OP_BE64_A 8'hd8
`define FPSC_OP_BE64_B 8'hdc
`define FPSC_OP_CE_A 8'hc7
`define FPSC_OP_CE_B 8'h60
`define FPSC_OP_PP_A 8'h02
`define FPSC_OP_PP_B 8'h12
`define FPSC_OP_QPP_A 8'h32
`define FPSC_OP_QPP_B 8'h34
`define FPSC_OP_EPP_A 8'hc2
`define FPSC_OP_EPP_B 8'h3e

// ****************************************
// framing
// ****************************************
`define FPSC_BYTE_CLKS_SPI 8'h08
`define FPSC_BYTE_CLKS_QUAD 8'h02
`define FPSC_ID_QUAD_DUMMY 8'h08
`define FPSC_UID_FRAME_BYTES_3B 8'h05
`define FPSC_UID_FRAME_BYTES_4B 8'h06
`define FPSC_CNT_MAX 8'hff
`define FPSC_SUSP_PROG_BIT 0
`define FPSC_SUSP_ERASE_BIT 1

// ****************************************
// timing
// ****************************************
`define FPSC_CLK_MHZ 250
`define FPSC_SLEEP_ENTRY_NS 3000
`define FPSC_WAKE_RECOVERY_NS 8000
`define FPSC_SUSPEND_MAX_NS 40000
`define FPSC_RESUME_MAX_NS 200
`define FPSC_SLEEP_ENTRY_CYC ((`FPSC_SLEEP_ENTRY_NS * `FPSC_CLK_MHZ + 999) / 1000)
`define FPSC_WAKE_RECOVERY_CYC ((`FPSC_WAKE_RECOVERY_NS * `FPSC_CLK_MHZ + 999) / 1000)
`define FPSC_SUSPEND_MAX_CYC ((`FPSC_SUSPEND_MAX_NS * `FPSC_CLK_MHZ) / 1000)
`define FPSC_RESUME_MAX_CYC ((`FPSC_RESUME_MAX_NS * `FPSC_CLK_MHZ) / 1000)

`endif

/* File: test/fpsc_ctrl_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module fpsc_ctrl_checker #(
  parameter [15:0] SUSPEND_MAX_CYC = 16'h0008
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_quad_mode,
  input wire logic i_cycle_start,
  input wire logic [3:0] o_io_oe,
  input wire logic o_busy_cycle_flag,
  input wire logic [1:0] o_suspend_flags,
  input wire logic o_array_halt,
  input wire logic o_deep_sleep,
  input wire logic o_standby,
  input wire logic o_soft_reset
);
  reg [15:0] halt_cnt_r;
  // counts how long busy outlives an accepted pause
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) halt_cnt_r <= 16'h0000;
    else if (o_array_halt && o_busy_cycle_flag) halt_cnt_r <= halt_cnt_r + 16'h0001;
    else halt_cnt_r <= 16'h0000;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sleep_quiet_io_a: assert property (o_deep_sleep |-> o_io_oe == 4'h0)
    else $error("data pins driven in deep sleep");
  sleep_not_busy_a: assert property ($rose(o_deep_sleep) |-> !o_busy_cycle_flag)
    else $error("deep sleep entered during a busy cycle");
  standby_awake_a: assert property (o_standby |-> !o_busy_cycle_flag && !o_deep_sleep)
    else $error("standby while busy or asleep");
  deselect_oe_a: assert property (i_cs_n [*5] |-> o_io_oe == 4'h0)
    else $error("pins driven while deselected");
  lane_oe_a: assert property (o_io_oe != 4'h0 |-> o_io_oe == (i_quad_mode ? 4'hf : 4'h2))
    else $error("wrong output lanes");
  one_kind_a: assert property (o_suspend_flags != 2'b11)
    else $error("both suspend flags set");
  pause_busy_a: assert property ($rose(|o_suspend_flags) |-> $past(o_busy_cycle_flag) && o_array_halt)
    else $error("suspend without busy cycle or halt");
  pause_latency_a: assert property (halt_cnt_r <= SUSPEND_MAX_CYC + 16'h0002)
    else $error("busy held too long after pause");
  busy_cause_a: assert property ($rose(o_busy_cycle_flag) |-> $past(i_cycle_start) || $past(|o_suspend_flags))
    else $error("busy set without start or resume");
  soft_reset_a: assert property (o_soft_reset |-> ##[0:2] (o_suspend_flags == 2'b00 && !o_deep_sleep))
    else $error("reset pair left suspend or sleep");
  cover property ($rose(o_deep_sleep));
  cover property ($rose(o_suspend_flags[1]));
  cover property (o_soft_reset);
  cover property (o_io_oe == 4'hf);
endmodule // fpsc_ctrl_checker
bind fpsc_ctrl fpsc_ctrl_checker #(.SUSPEND_MAX_CYC(SUSPEND_MAX_CYC)) u_chk (.i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_quad_mode(i_quad_mode), .i_cycle_start(i_cycle_start),
  .o_io_oe(o_io_oe), .o_busy_cycle_flag(o_busy_cycle_flag), .o_suspend_flags(o_suspend_flags),
  .o_array_halt(o_array_halt), .o_deep_sleep(o_deep_sleep), .o_standby(o_standby), .o_soft_reset(o_soft_reset));
`default_nettype wire

/* File: test/fpsc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module fpsc_host (
  input wire logic i_ref_clk,
  input wire logic i_quad,
  input wire logic [3:0] i_io,
  output logic o_cs_n,
  output logic o_sclk,
  output logic [3:0] o_io
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'h0;
  end
  // sclk idles low outside frames; released lines toggle so stale data never passes
  task automatic frame(input logic [7:0] code, input int n_wr, input int n_rd, output logic [31:0] rd);
    logic [47:0] sh;
    sh = {code, 40'h0};
    rd = 32'h0;
    @(negedge i_ref_clk);
    o_cs_n = 1'b0;
    for (int k = 0; k < n_wr + n_rd; k++) begin
      o_io = (k >= n_wr) ? ~o_io : (i_quad ? sh[47:44] : {~o_io[3:1], sh[47]});
      sh = i_quad ? sh << 4 : sh << 1;
      repeat (4) @(negedge i_ref_clk);
      o_sclk = 1'b1;
      if (k >= n_wr) rd = i_quad ? {rd[27:0], i_io} : {rd[30:0], i_io[1]};
      repeat (4) @(negedge i_ref_clk);
      o_sclk = 1'b0;
    end
    repeat (4) @(negedge i_ref_clk);
    o_cs_n = 1'b1;
    o_io = ~o_io;
  endtask
endmodule // fpsc_host
`default_nettype wire

/* File: test/test_flash_power_id_suspend_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module test_flash_power_id_suspend_ctrl;
  localparam [15:0] SLP = 16'h0004;
  localparam [15:0] WAK = 16'h0004;
  localparam [15:0] SUS = 16'h0008;
  localparam [127:0] UID = 128'hc3a50f1e_77d2_4b69_8e10_5f3ca28b91e4; // arbitrary value
  localparam [31:0] IDW = 32'h6b2d1700; // arbitrary value
  logic clk, rst_n, quad, a4, fast, cstart, is_prog, is_erase, cdone, cs_n, sclk;
  logic busy, halt, deep, stby, cvld, srst;
  logic [3:0] host_o, dut_o, dut_oe, pin;
  logic [1:0] susp;
  logic [7:0] ccode, e_code;
  logic [31:0] rd;
  logic [15:0] lfsr;
  logic [7:0] exp_q[$];
  logic [7:0] bad [0:17] = '{8'h01, 8'hb1, 8'h44, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60,
    8'h42, 8'h02, 8'h12, 8'h32, 8'h34, 8'hc2, 8'h3e};
  int n_fail, samples_checked, n_srst;
  assign pin = (dut_oe & dut_o) | (~dut_oe & host_o);
  always #2 clk = ~clk;
  fpsc_host u_host (.i_ref_clk(clk), .i_quad(quad), .i_io(pin), .o_cs_n(cs_n), .o_sclk(sclk), .o_io(host_o));
  fpsc_ctrl #(.SLEEP_ENTRY_CYC(SLP), .WAKE_RECOVERY_CYC(WAK), .SUSPEND_MAX_CYC(SUS), .UNIQUE_ID(UID),
    .MAKER_ID(IDW[31:24]), .MEM_TYPE_ID(IDW[23:16]), .CAPACITY_ID(IDW[15:8]), .EXTRA_ID(IDW[7:0])) u_dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_io(pin), .i_quad_mode(quad),
    .i_addr4_mode(a4), .i_sclk_fast(fast), .i_cycle_start(cstart), .i_cycle_is_prog(is_prog),
    .i_cycle_is_erase(is_erase), .i_cycle_done(cdone), .o_io(dut_o), .o_io_oe(dut_oe),
    .o_busy_cycle_flag(busy), .o_suspend_flags(susp), .o_array_halt(halt), .o_deep_sleep(deep),
    .o_standby(stby), .o_cmd_valid(cvld), .o_cmd_code(ccode), .o_soft_reset(srst));
  function automatic logic [15:0] step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c, input int n_wr, input int n_rd);
    u_host.frame(c, n_wr, n_rd, rd);
    lfsr = step(lfsr);
    repeat (6 + lfsr[2:0]) @(negedge clk);
  endtask
  task automatic cyc(input logic p, input logic e);
    is_prog = p;
    is_erase = e;
    cstart = 1'b1;
    @(negedge clk);
    cstart = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // ****************************************
  // result watcher
  // ****************************************
  always @(posedge clk) begin
    if (srst === 1'b1) n_srst++;
    if (cvld === 1'b1) begin
      if (exp_q.size() > 0) begin
        e_code = exp_q.pop_front();
        `CHK(ccode, e_code)
      end
      else `CHK(1'b0, 1'b1)
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    summarize();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {clk, rst_n, quad, a4, fast, cstart, is_prog, is_erase, cdone} = 9'h000;
    lfsr = 16'h2746;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK({deep, stby, busy, susp}, 5'h08)
    cmd(8'h9f, 8, 32);
    `CHK(rd, IDW)
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back({4'h0, lfsr[3:0]});
      cmd({4'h0, lfsr[3:0]}, 8, 0);
    end
    cmd(8'h4b, 40, 32);
    `CHK(rd, UID[127:96])
    a4 = 1'b1;
    cmd(8'h4b, 48, 32);
    `CHK(rd, UID[127:96])
    a4 = 1'b0;
    quad = 1'b1;
    fast = 1'b1;
    cmd(8'h9f, 10, 8);
    `CHK(rd, IDW)
    fast = 1'b0;
    cmd(8'h9f, 2, 8);
    `CHK(rd, IDW)
    quad = 1'b0;
    cmd(8'hb9, 9, 0);
    repeat (SLP + 8) @(negedge clk);
    `CHK(deep, 1'b0)
    u_host.frame(8'hb9, 8, 0, rd);
    repeat (3) @(negedge clk);
    `CHK(deep, 1'b0)
    repeat (SLP + 6) @(negedge clk);
    `CHK({deep, stby}, 2'b10)
    cmd(8'h03, 8, 0);
    cmd(8'h9f, 8, 32);
    cmd(8'hab, 8, 0);
    `CHK(deep, 1'b0)
    repeat (WAK + 4) @(negedge clk);
    exp_q.push_back(8'h05);
    cmd(8'h05, 8, 0);
    cmd(8'hb9, 8, 0);
    repeat (SLP + 8) @(negedge clk);
    cmd(8'h66, 8, 0);
    cmd(8'h99, 8, 0);
    `CHK(deep, 1'b0)
    `CHK(n_srst, 1)
    cyc(1'b1, 1'b0);
    `CHK(busy, 1'b1)
    cmd(8'hb9, 8, 0);
    repeat (SLP + 8) @(negedge clk);
    `CHK({deep, busy}, 2'b01)
    cmd(8'hab, 8, 0);
    `CHK(busy, 1'b1)
    cmd(8'h9f, 8, 32);
    cmd(8'h75, 8, 0);
    `CHK({susp, halt}, 3'b011)
    repeat (SUS + 4) @(negedge clk);
    `CHK(busy, 1'b0)
    for (int i = 0; i < 18; i++) cmd(bad[i], 8, 0);
    exp_q.push_back(8'h03);
    cmd(8'h03, 8, 0);
    cmd(8'h75, 8, 0);
    `CHK(susp, 2'b01)
    cmd(8'h7a, 8, 0);
    `CHK({susp, busy}, 3'b001)
    cdone = 1'b1;
    @(negedge clk);
    cdone = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(busy, 1'b0)
    cmd(8'h75, 8, 0);
    `CHK(susp, 2'b00)
    cyc(1'b0, 1'b1);
    cmd(8'h75, 8, 0);
    `CHK(susp, 2'b10)
    for (int i = 0; i < 11; i++) cmd(bad[i], 8, 0);
    exp_q.push_back(8'h42);
    cmd(8'h42, 8, 0);
    cmd(8'h66, 8, 0);
    cmd(8'h99, 8, 0);
    `CHK({susp, halt}, 3'b000)
    `CHK(exp_q.size(), 0)
    summarize();
  end
endmodule // test_flash_power_id_suspend_ctrl
`default_nettype wire
